/* hw/hdlc_map.vh */
`ifndef HDLC_MAP_VH
`define HDLC_MAP_VH
// Register byte offsets
`define A_CHSEL   8'h00
`define A_CFG     8'h04
`define A_STAT    8'h08
`define A_RXD     8'h0c
`define A_TXD     8'h10
// Config fields
`define C_IDLE    0
`define C_ECHO    1
`define C_LOOP    2
`define C_HALT    3
`define CFG_RST   8'h00
// Status bits
`define S_DONE    0
`define S_CRC     1
`define S_RABT    2
`define S_OVR     3
`define S_LLI     4
`define S_STC     5
`define S_IDL     6
`define S_UNR     0
`define S_TABT    1
`define S_SENT    2
// Line patterns
`define P_FLAG    8'h7e
`define P_ABORT   8'h7f
`define P_IDLE    8'hff
// Check word
`define CRC_INIT  16'hffff
`define CRC_POLY  16'h8408
`define CRC_GOOD  16'hf0b8
// Buffer sizes and thresholds
`define RX_DEPTH  3'd6
`define TX_DEPTH  3'd4
`define CRC_BYTES 3'd2
`define ABT_MIN   3'd3
`define IDLE_ONES 4'd15
`define IDLE_LAST 4'd14
`define FLAG_ONES 4'd6
`define STUF_ONES 4'd5
`endif

/* hw/hdlc_tdm_transceiver.v */
`include "hdlc_map.vh"
module hdlc_tdm_transceiver (
  input  wire        sys_clk,          // System clock
  input  wire        rst_n,            // Async reset
  input  wire        wb_cyc_i,         // Bus cycle
  input  wire        wb_stb_i,         // Bus strobe
  input  wire        wb_we_i,          // Write enable
  input  wire [7:0]  wb_adr_i,         // Byte address
  input  wire [3:0]  wb_sel_i,         // Byte lanes
  input  wire [31:0] wb_dat_i,         // Write data
  output reg  [31:0] wb_dat_o,         // Read data
  output reg         wb_ack_o,         // Acknowledge
  input  wire        rx_line,          // Serial receive data
  input  wire        rx_line_clock,    // Receive bit clock
  input  wire        rx_slot_strobe,   // Receive slot valid
  input  wire [2:0]  rx_slot_number,   // Receive channel
  input  wire        serial_out_clock, // Transmit bit clock
  input  wire        tx_slot_strobe,   // Transmit slot valid
  input  wire [2:0]  tx_slot_number,   // Transmit channel
  output reg         serial_out_line   // Serial transmit data
);

localparam T_FILL  = 8'h01;
localparam T_OPEN  = 8'h02;
localparam T_DATA  = 8'h04;
localparam T_CRCL  = 8'h08;
localparam T_CRCH  = 8'h10;
localparam T_CLOSE = 8'h20;
localparam T_TRAIL = 8'h40;
localparam T_ABORT = 8'h80;

////////////////////////////////////////////////////////////////////////////////
// Helpers

function [15:0] crc_step;
  input [15:0] c;
  input        b;
  begin
    crc_step = (c[0] ^ b) ? ((c >> 1) ^ `CRC_POLY) : (c >> 1);
  end
endfunction

function [2:0] wrap6;
  input [3:0] v;
  reg   [3:0] t;
  begin
    t = (v >= 4'd6) ? v - 4'd6 : v;
    wrap6 = t[2:0];
  end
endfunction

function [5:0] ridx;
  input [2:0] ch;
  input [2:0] p;
  begin
    ridx = {ch, 3'b000} - {2'b00, ch, 1'b0} + {3'b000, p};
  end
endfunction

function [2:0] rx_hold;
  input [2:0] fb;
  begin
    rx_hold = (fb >= `CRC_BYTES) ? `CRC_BYTES : fb;
  end
endfunction

////////////////////////////////////////////////////////////////////////////////
// Pin synchronisers and edge detection

wire [10:0] pins = {rx_line_clock, rx_line, rx_slot_strobe, rx_slot_number,
                    serial_out_clock, tx_slot_strobe, tx_slot_number};
reg  [10:0] s1;
reg  [10:0] s2;
reg  [10:0] s3;
reg  [10:0] pf;
reg  [10:0] pp;

// Three stages; level moves once stages two and three agree
always @(posedge sys_clk or negedge rst_n)
begin
  if (!rst_n)
  begin
    // Bit clocks park high, so no false edge follows reset
    s1 <= 11'h410;
    s2 <= 11'h410;
    s3 <= 11'h410;
    pf <= 11'h410;
    pp <= 11'h410;
  end
  else
  begin
    s1 <= pins;
    s2 <= s1;
    s3 <= s2;
    pf <= ((s2 ~^ s3) & s3) | ((s2 ^ s3) & pf);
    pp <= pf;
  end
end

wire       rx_go = pf[10] & ~pp[10] & pf[8];
wire       tx_go = ~pf[4] & pp[4] & pf[3];
wire [2:0] rc    = pf[7:5];
wire [2:0] tc    = pf[2:0];

////////////////////////////////////////////////////////////////////////////////
// Per-channel state

reg [2:0]  chsel;
reg [7:0]  cfg     [0:7];
reg [6:0]  r_stat  [0:7];
reg [2:0]  t_stat  [0:7];
reg [3:0]  r_ones  [0:7];
reg [6:0]  r_dly   [0:7];
reg [2:0]  r_dfill [0:7];
reg [7:0]  r_sh    [0:7];
reg [2:0]  r_bc    [0:7];
reg        r_in    [0:7];
reg [2:0]  r_fb    [0:7];
reg [15:0] r_crc   [0:7];
reg [2:0]  r_cnt   [0:7];
reg [2:0]  r_rd    [0:7];
reg [7:0]  r_mem   [0:47];
reg        e_bit   [0:7];
reg [7:0]  t_st    [0:7];
reg [7:0]  t_sh    [0:7];
reg [2:0]  t_bc    [0:7];
reg [2:0]  t_ones  [0:7];
reg [15:0] t_crc   [0:7];
reg [3:0]  t_tr    [0:7];
reg        t_last  [0:7];
reg        t_halt  [0:7];
reg        t_prev  [0:7];
reg [2:0]  t_cnt   [0:7];
reg [1:0]  t_rd    [0:7];
reg [8:0]  t_mem   [0:31];

////////////////////////////////////////////////////////////////////////////////
// Receive decode

wire       rb     = cfg[rc][`C_LOOP] ? t_prev[rc] : pf[9];
wire [3:0] ro     = r_ones[rc];
wire [2:0] rf     = r_dfill[rc];
wire [2:0] rcnt   = r_cnt[rc];
wire [2:0] rfb    = r_fb[rc];
wire       rpush  = rb ? (ro < `FLAG_ONES) : (ro != `STUF_ONES && ro != `FLAG_ONES);
wire       rout   = r_dly[rc][6];
wire       remit  = rpush && rf == 3'd7 && r_in[rc];
wire [7:0] rbyte  = {rout, r_sh[rc][7:1]};
wire [15:0] rcrc  = crc_step(r_crc[rc], rout);
wire       rflag  = !rb && ro == `FLAG_ONES;
wire       rabort = rb && ro == `FLAG_ONES;
wire       ridle  = rb && ro == `IDLE_LAST;
wire       rclose = r_in[rc] && rfb != 3'd0;
wire       rbad   = r_crc[rc] != `CRC_GOOD || r_bc[rc] != 3'd0 || rfb < `CRC_BYTES;
wire [2:0] rdrop  = (rfb > rcnt) ? rcnt : rfb;
wire       rbig   = rfb >= `ABT_MIN;
wire [5:0] rwi    = ridx(rc, wrap6({1'b0, r_rd[rc]} + {1'b0, rcnt}));

// Closing flag status, idle ended by flags
wire [6:0] fset = ({6'h00, rclose} << `S_DONE)
                | ({6'h00, rclose & rbad} << `S_CRC)
                | ({6'h00, rclose & r_stat[rc][`S_OVR]} << `S_LLI)
                | ({6'h00, r_stat[rc][`S_IDL]} << `S_STC);
// Abort status
wire [6:0] aset = ({6'h00, r_in[rc] & rbig} << `S_RABT)
                | ({6'h00, r_in[rc] & rbig & (rcnt > rfb)} << `S_LLI);

////////////////////////////////////////////////////////////////////////////////
// Transmit decode

wire [7:0]  ts     = t_st[tc];
wire [7:0]  tsh    = t_sh[tc];
wire [2:0]  tbc    = t_bc[tc];
wire [2:0]  tcnt   = t_cnt[tc];
wire        techo  = cfg[tc][`C_ECHO];
wire        tcount = (ts & (T_DATA | T_CRCL | T_CRCH)) != 8'h00;
wire        tstuff = t_ones[tc] == 3'd5 && (tcount || (ts == T_CLOSE && tbc == 3'd0));
wire        tb     = techo ? e_bit[tc] : (tstuff ? 1'b0 : tsh[0]);
wire [15:0] tcrc   = crc_step(t_crc[tc], tsh[0]);
wire [7:0]  tfill  = cfg[tc][`C_IDLE] ? `P_IDLE : `P_FLAG;
wire [8:0]  tpop   = t_mem[{tc, t_rd[tc]}];

////////////////////////////////////////////////////////////////////////////////
// Bus decode

wire       req    = wb_cyc_i & wb_stb_i & ~wb_ack_o;
wire       busy   = (rx_go && rc == chsel) || (tx_go && tc == chsel);
wire       take   = req & ~busy;
wire       wr     = take & wb_we_i;
wire       havail = r_cnt[chsel] > rx_hold(r_fb[chsel]);
wire [5:0] hidx   = ridx(chsel, r_rd[chsel]);
wire       pop    = take & ~wb_we_i & wb_adr_i == `A_RXD & havail;
wire       push   = wr & wb_adr_i == `A_TXD & wb_sel_i[0] & t_cnt[chsel] < `TX_DEPTH;
wire [1:0] hwp    = t_rd[chsel] + t_cnt[chsel][1:0];
wire [9:0] clr    = wb_dat_i[9:0] & {{2{wb_sel_i[1]}}, {8{wb_sel_i[0]}}};
reg  [31:0] rdata;

// Read mux
always @*
begin
  case (wb_adr_i)
    `A_CHSEL: rdata = {29'h0, chsel};
    `A_CFG:   rdata = {24'h0, cfg[chsel]};
    `A_STAT:  rdata = {16'h0, t_cnt[chsel], r_cnt[chsel], t_stat[chsel], r_stat[chsel]};
    `A_RXD:   rdata = {23'h0, havail, r_mem[hidx]};
    default:  rdata = 32'h0;
  endcase
end

////////////////////////////////////////////////////////////////////////////////
// Channel engine and register file

integer i;
always @(posedge sys_clk or negedge rst_n)
begin
  if (!rst_n)
  begin
    chsel <= 3'h0;
    wb_ack_o <= 1'b0;
    wb_dat_o <= 32'h0;
    serial_out_line <= 1'b1;
    for (i = 0; i < 8; i = i + 1)
    begin
      cfg[i] <= `CFG_RST;
      r_stat[i] <= 7'h00;
      t_stat[i] <= 3'h0;
      r_ones[i] <= 4'h0;
      r_dly[i] <= 7'h00;
      r_dfill[i] <= 3'h0;
      r_sh[i] <= 8'h00;
      r_bc[i] <= 3'h0;
      r_in[i] <= 1'b0;
      r_fb[i] <= 3'h0;
      r_crc[i] <= `CRC_INIT;
      r_cnt[i] <= 3'h0;
      r_rd[i] <= 3'h0;
      e_bit[i] <= 1'b1;
      t_st[i] <= T_FILL;
      t_sh[i] <= `P_FLAG;
      t_bc[i] <= 3'h0;
      t_ones[i] <= 3'h0;
      t_crc[i] <= `CRC_INIT;
      t_tr[i] <= 4'h0;
      t_last[i] <= 1'b0;
      t_halt[i] <= 1'b0;
      t_prev[i] <= 1'b1;
      t_cnt[i] <= 3'h0;
      t_rd[i] <= 2'h0;
    end
    for (i = 0; i < 48; i = i + 1)
      r_mem[i] <= 8'h00;
    for (i = 0; i < 32; i = i + 1)
      t_mem[i] <= 9'h000;
  end
  else
  begin
    // Receive bit for the addressed channel
    if (rx_go)
    begin
      e_bit[rc] <= rb;
      if (!cfg[rc][`C_ECHO])
      begin
        r_ones[rc] <= rb ? ((ro == `IDLE_ONES) ? ro : ro + 4'd1) : 4'h0;
        // Seven-bit delay hides flag bits from data
        if (rpush)
        begin
          r_dly[rc] <= {r_dly[rc][5:0], rb};
          r_dfill[rc] <= (rf == 3'd7) ? rf : rf + 3'd1;
        end
        if (remit)
        begin
          r_crc[rc] <= rcrc;
          r_sh[rc] <= rbyte;
          r_bc[rc] <= r_bc[rc] + 3'd1;
          if (r_bc[rc] == 3'd7)
          begin
            r_fb[rc] <= (rfb == 3'd7) ? rfb : rfb + 3'd1;
            if (rcnt == `RX_DEPTH)
              r_stat[rc] <= r_stat[rc] | (7'h01 << `S_OVR);
            else
            begin
              r_mem[rwi] <= rbyte;
              r_cnt[rc] <= rcnt + 3'd1;
            end
          end
        end
        if (ridle && !r_stat[rc][`S_IDL])
          r_stat[rc] <= r_stat[rc] | (7'h01 << `S_IDL) | (7'h01 << `S_STC);
        // Flag: close frame, open next
        if (rflag)
        begin
          r_stat[rc] <= (r_stat[rc] & ~(7'h01 << `S_IDL)) | fset;
          if (rclose)
            r_cnt[rc] <= rcnt - rx_hold(rfb);
          r_in[rc] <= 1'b1;
          r_dfill[rc] <= 3'h0;
          r_fb[rc] <= 3'h0;
          r_bc[rc] <= 3'h0;
          r_crc[rc] <= `CRC_INIT;
        end
        // Abort: drop frame, clear check
        if (rabort)
        begin
          r_stat[rc] <= r_stat[rc] | aset;
          if (r_in[rc])
            r_cnt[rc] <= rcnt - rdrop;
          r_in[rc] <= 1'b0;
          r_dfill[rc] <= 3'h0;
          r_fb[rc] <= 3'h0;
          r_bc[rc] <= 3'h0;
          r_crc[rc] <= `CRC_INIT;
        end
      end
    end
    // Transmit bit for the addressed channel
    if (tx_go)
    begin
      serial_out_line <= tb;
      t_prev[tc] <= tb;
      if (!techo && tstuff)
        t_ones[tc] <= 3'h0;
      else if (!techo)
      begin
        t_ones[tc] <= (tcount && tsh[0]) ? t_ones[tc] + 3'd1 : 3'h0;
        if (ts == T_DATA)
          t_crc[tc] <= tcrc;
        t_sh[tc] <= {1'b0, tsh[7:1]};
        t_bc[tc] <= tbc + 3'd1;
        // Byte boundary decisions
        if (tbc == 3'd7)
        begin
          case (ts)
            T_FILL:
            begin
              t_halt[tc] <= 1'b0;
              if (tcnt != 3'h0)
              begin
                t_st[tc] <= T_OPEN;
                t_sh[tc] <= `P_FLAG;
              end
              else
                t_sh[tc] <= tfill;
            end
            T_OPEN:
            begin
              t_st[tc] <= T_DATA;
              t_crc[tc] <= `CRC_INIT;
              t_sh[tc] <= tpop[7:0];
              t_last[tc] <= tpop[8];
              t_rd[tc] <= t_rd[tc] + 2'd1;
              t_cnt[tc] <= tcnt - 3'd1;
            end
            T_DATA:
            begin
              if (t_halt[tc])
              begin
                t_st[tc] <= T_ABORT;
                t_sh[tc] <= `P_ABORT;
                t_halt[tc] <= 1'b0;
                t_stat[tc] <= t_stat[tc] | (3'h1 << `S_TABT);
              end
              else if (t_last[tc])
              begin
                t_st[tc] <= T_CRCL;
                t_sh[tc] <= ~tcrc[7:0];
              end
              else if (tcnt == 3'h0)
              begin
                t_st[tc] <= T_ABORT;
                t_sh[tc] <= `P_ABORT;
                t_stat[tc] <= t_stat[tc] | (3'h1 << `S_UNR);
              end
              else
              begin
                t_sh[tc] <= tpop[7:0];
                t_last[tc] <= tpop[8];
                t_rd[tc] <= t_rd[tc] + 2'd1;
                t_cnt[tc] <= tcnt - 3'd1;
              end
            end
            T_CRCL:
            begin
              t_st[tc] <= T_CRCH;
              t_sh[tc] <= ~t_crc[tc][15:8];
            end
            T_CRCH:
            begin
              t_st[tc] <= T_CLOSE;
              t_sh[tc] <= `P_FLAG;
            end
            T_CLOSE:
            begin
              t_stat[tc] <= t_stat[tc] | (3'h1 << `S_SENT);
              if (cfg[tc][7:4] != 4'h0)
              begin
                t_st[tc] <= T_TRAIL;
                t_tr[tc] <= cfg[tc][7:4] - 4'd1;
                t_sh[tc] <= `P_FLAG;
              end
              else
              begin
                t_st[tc] <= T_FILL;
                t_sh[tc] <= tfill;
              end
            end
            T_TRAIL:
            begin
              if (t_tr[tc] == 4'h0)
              begin
                t_st[tc] <= T_FILL;
                t_sh[tc] <= tfill;
              end
              else
              begin
                t_tr[tc] <= t_tr[tc] - 4'd1;
                t_sh[tc] <= `P_FLAG;
              end
            end
            T_ABORT:
            begin
              t_st[tc] <= T_FILL;
              t_sh[tc] <= tfill;
            end
            default:
            begin
              t_st[tc] <= T_FILL;
              t_sh[tc] <= tfill;
            end
          endcase
        end
      end
    end
    // Bus slave: one-cycle answer, held off while channel busy
    wb_ack_o <= take;
    if (take && !wb_we_i)
      wb_dat_o <= rdata;
    if (wr && wb_adr_i == `A_CHSEL && wb_sel_i[0])
      chsel <= wb_dat_i[2:0];
    if (wr && wb_adr_i == `A_CFG && wb_sel_i[0])
    begin
      cfg[chsel] <= wb_dat_i[7:0] & ~(8'h01 << `C_HALT);
      if (wb_dat_i[`C_HALT])
        t_halt[chsel] <= 1'b1;
    end
    if (wr && wb_adr_i == `A_STAT)
    begin
      r_stat[chsel] <= r_stat[chsel] & ~(clr[6:0] & ~(7'h01 << `S_IDL));
      t_stat[chsel] <= t_stat[chsel] & ~clr[9:7];
    end
    if (pop)
    begin
      r_rd[chsel] <= wrap6({1'b0, r_rd[chsel]} + 4'd1);
      r_cnt[chsel] <= r_cnt[chsel] - 3'd1;
    end
    if (push)
    begin
      t_mem[{chsel, hwp}] <= wb_dat_i[8:0];
      t_cnt[chsel] <= t_cnt[chsel] + 3'd1;
    end
  end
end

endmodule

/* tb/hdlc_tdm_transceiver_sva.sv */
module hdlc_tdm_transceiver_chk (
  input wire        sys_clk,          // clock
  input wire        rst_n,            // reset
  input wire        wb_cyc_i,         // cycle
  input wire        wb_stb_i,         // strobe
  input wire        wb_we_i,          // write
  input wire [7:0]  wb_adr_i,         // address
  input wire [3:0]  wb_sel_i,         // lanes
  input wire [31:0] wb_dat_i,         // write data
  input wire [31:0] wb_dat_o,         // read data
  input wire        wb_ack_o,         // ack
  input wire        rx_line,          // rx data
  input wire        rx_line_clock,    // rx clock
  input wire        rx_slot_strobe,   // rx slot
  input wire [2:0]  rx_slot_number,   // rx channel
  input wire        serial_out_clock, // tx clock
  input wire        tx_slot_strobe,   // tx slot
  input wire [2:0]  tx_slot_number,   // tx channel
  input wire        serial_out_line   // tx data
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [3:0] since_fall;
  logic       clk_q;

  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!rst_n);

  ////////////////////////////////////////////////////////////////
  // Cycles since a selected falling tx clock
  always_ff @(posedge sys_clk or negedge rst_n)
    if (!rst_n)
    begin
      since_fall <= 4'hf;
      clk_q      <= 1'b1;
    end
    else
    begin
      clk_q <= serial_out_clock;
      if (clk_q && !serial_out_clock && tx_slot_strobe)
        since_fall <= 4'h0;
      else if (since_fall != 4'hf)
        since_fall <= since_fall + 4'h1;
    end

  ////////////////////////////////////////////////////////////////
  // Bus handshake, read values and tx line timing
  a_ack_one_cycle: assert property (wb_ack_o |=> !wb_ack_o)
    else $error("ack longer than one cycle");
  a_ack_has_request: assert property (wb_ack_o |-> wb_cyc_i && wb_stb_i)
    else $error("ack without request");
  a_ack_latency: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o |-> ##[1:2] wb_ack_o)
    else $error("ack late");
  a_unmapped_zero: assert property (wb_ack_o && !wb_we_i && wb_adr_i > 8'h10 |-> wb_dat_o == 32'h0)
    else $error("unmapped read not zero");
  a_halt_reads_zero: assert property (wb_ack_o && !wb_we_i && wb_adr_i == 8'h04 |-> !wb_dat_o[3])
    else $error("halt bit reads one");
  a_write_keeps_data: assert property (wb_ack_o && wb_we_i |-> $stable(wb_dat_o))
    else $error("read data moved on write");
  a_rx_count_max: assert property (wb_ack_o && !wb_we_i && wb_adr_i == 8'h08 |-> wb_dat_o[12:10] <= 3'd6)
    else $error("rx count above six");
  a_tx_count_max: assert property (wb_ack_o && !wb_we_i && wb_adr_i == 8'h08 |-> wb_dat_o[15:13] <= 3'd4)
    else $error("tx count above four");
  a_line_after_edge: assert property ($changed(serial_out_line) |-> since_fall < 4'hc)
    else $error("tx line moved without a selected edge");
endmodule

bind hdlc_tdm_transceiver hdlc_tdm_transceiver_chk i_hdlc_tdm_transceiver_chk (
  .sys_clk(sys_clk), .rst_n(rst_n), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i),
  .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o),
  .wb_ack_o(wb_ack_o), .rx_line(rx_line), .rx_line_clock(rx_line_clock),
  .rx_slot_strobe(rx_slot_strobe), .rx_slot_number(rx_slot_number),
  .serial_out_clock(serial_out_clock), .tx_slot_strobe(tx_slot_strobe),
  .tx_slot_number(tx_slot_number), .serial_out_line(serial_out_line));

/* tb/line_partner.sv */
module line_partner (
  output logic       rx_line,          // rx data
  output logic       rx_line_clock,    // rx clock
  output logic       rx_slot_strobe,   // rx slot
  output logic [2:0] rx_slot_number,   // rx channel
  output logic       serial_out_clock, // tx clock
  output logic       tx_slot_strobe,   // tx slot
  output logic [2:0] tx_slot_number,   // tx channel
  input  wire        serial_out_line   // tx data
);
  timeunit 1ns;
  timeprecision 1ns;

  ////////////////////////////////////////////////////////////////
  // Parked line: clocks high, no slot selected
  initial
  begin
    rx_line          = 1'b1;
    rx_line_clock    = 1'b1;
    rx_slot_strobe   = 1'b0;
    rx_slot_number   = 3'h0;
    serial_out_clock = 1'b1;
    tx_slot_strobe   = 1'b0;
    tx_slot_number   = 3'h0;
  end

  ////////////////////////////////////////////////////////////////
  // One 800 ns slot: rx bit on the rise, tx bit launched by the fall
  task slot(input logic rb, rs, input logic [2:0] rc, input logic ts, input logic [2:0] tc, output logic tbit);
    #5;
    rx_slot_strobe = rs;
    rx_slot_number = rc;
    tx_slot_strobe = ts;
    tx_slot_number = tc;
    rx_line        = rs ? rb : ~rx_line;
    #8;
    rx_line_clock    = 1'b0;
    serial_out_clock = 1'b0;
    #400;
    rx_line_clock    = 1'b1;
    serial_out_clock = 1'b1;
    #387;
    tbit = serial_out_line;
  endtask
endmodule

/* tb/hdlc_tdm_transceiver_tb.sv */
`include "hdlc_map.vh"
module hdlc_tdm_transceiver_tb;
  timeunit 1ns;
  timeprecision 1ns;
  logic        sys_clk, rst_n, wb_cyc_i, wb_stb_i, wb_we_i, wb_ack_o;
  logic [7:0]  wb_adr_i;
  logic [3:0]  wb_sel_i;
  logic [31:0] wb_dat_i, wb_dat_o, q;
  logic        rx_line, rx_line_clock, rx_slot_strobe, serial_out_clock, tx_slot_strobe, serial_out_line;
  logic [2:0]  rx_slot_number, tx_slot_number;
  logic        ex[$], got[$];
  logic [15:0] crc;
  logic [7:0]  d[3] = '{8'h1f, 8'hbe, 8'h42};
  int          ones, n_fail = 0, n_tests = 0;

  hdlc_tdm_transceiver i_hdlc_tdm_transceiver (
    .sys_clk(sys_clk), .rst_n(rst_n), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i),
    .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o),
    .wb_ack_o(wb_ack_o), .rx_line(rx_line), .rx_line_clock(rx_line_clock),
    .rx_slot_strobe(rx_slot_strobe), .rx_slot_number(rx_slot_number),
    .serial_out_clock(serial_out_clock), .tx_slot_strobe(tx_slot_strobe),
    .tx_slot_number(tx_slot_number), .serial_out_line(serial_out_line));
  line_partner i_line_partner (
    .rx_line(rx_line), .rx_line_clock(rx_line_clock), .rx_slot_strobe(rx_slot_strobe),
    .rx_slot_number(rx_slot_number), .serial_out_clock(serial_out_clock),
    .tx_slot_strobe(tx_slot_strobe), .tx_slot_number(tx_slot_number), .serial_out_line(serial_out_line));

  ////////////////////////////////////////////////////////////////
  // Clock
  initial
  begin
    sys_clk = 1'b0;
    forever #50 sys_clk = ~sys_clk;
  end

  ////////////////////////////////////////////////////////////////
  // Verdict, comparison and bus cycle
  task results;
    $display("tests %0d failures %0d", n_tests, n_fail);
    if (n_fail == 0 && n_tests > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask
  task chk(input logic [31:0] g, e);
    n_tests++;
    if (g !== e)
    begin
      n_fail++;
      $display("mismatch %0t: got %0h want %0h", $time, g, e);
    end
  endtask
  task wb(input logic we, input logic [7:0] a, input logic [31:0] w, output logic [31:0] r);
    int i;
    @(posedge sys_clk);
    wb_cyc_i <= 1'b1;
    wb_stb_i <= 1'b1;
    wb_we_i  <= we;
    wb_adr_i <= a;
    wb_dat_i <= w;
    for (i = 0; i < 20 && wb_ack_o !== 1'b1; i++)
      @(posedge sys_clk);
    if (i == 20)
    begin
      n_fail++;
      $display("mismatch %0t: bus timeout", $time);
      results;
    end
    r = wb_dat_o;
    wb_cyc_i <= 1'b0;
    wb_stb_i <= 1'b0;
    wb_we_i  <= 1'b0;
  endtask

  ////////////////////////////////////////////////////////////////
  // Expected line bits, LSB first, optional zero insertion
  task put(input logic [7:0] v, input bit stf);
    for (int k = 0; k < 8; k++)
    begin
      ex.push_back(v[k]);
      ones = v[k] ? ones + 1 : 0;
      if (stf && ones == 5)
      begin
        ex.push_back(1'b0);
        ones = 0;
      end
    end
  endtask
  task dat(input logic [7:0] v);
    for (int k = 0; k < 8; k++)
      crc = (crc >> 1) ^ ((crc[0] ^ v[k]) ? `CRC_POLY : 16'h0);
    put(v, 1);
  endtask
  task open;
    ex = {};
    crc = `CRC_INIT;
    put(`P_FLAG, 0);
    ones = 0;
  endtask
  task send(input logic [2:0] ch);
    logic t;
    foreach (ex[k])
      i_line_partner.slot(ex[k], 1'b1, ch, 1'b0, 3'h0, t);
  endtask

  ////////////////////////////////////////////////////////////////
  // Scenarios
  task regs_at_reset;
    wb(0, `A_CFG, 0, q);
    chk(q[7:0], `CFG_RST);
    wb(0, 8'h40, 0, q);
    chk(q, 0);
  endtask
  task tx_frame(input logic [2:0] ch, input bit under);
    logic b;
    int hit;
    wb(1, `A_CHSEL, {29'h0, ch}, q);
    wb(1, `A_CFG, 32'h11, q);
    wb(1, `A_TXD, {23'h0, 1'b0, 8'hfc}, q);
    if (!under)
      wb(1, `A_TXD, {23'h0, 1'b1, 8'h3f}, q);
    open;
    dat(8'hfc);
    if (under)
      put(`P_ABORT, 0);
    else
    begin
      dat(8'h3f);
      put(~crc[7:0], 1);
      put(~crc[15:8], 1);
      put(`P_FLAG, 0);
      put(`P_FLAG, 0);
    end
    put(`P_IDLE, 0);
    got = {};
    repeat (130)
    begin
      i_line_partner.slot(1'b0, 1'b0, 3'h0, 1'b1, ch, b);
      got.push_back(b);
    end
    hit = 0;
    for (int s = 0; s + ex.size() <= got.size(); s++)
    begin
      b = 1;
      foreach (ex[k])
        if (got[s + k] !== ex[k])
          b = 0;
      if (b)
        hit = 1;
    end
    chk(hit, 1);
    wb(0, `A_STAT, 0, q);
    chk(q[7], under);
    chk(q[9], !under);
  endtask
  task rx_frame;
    open;
    for (int k = 1; k < 8; k++)
      ex.push_back(k < 7);
    ones = 0;
    foreach (d[k])
      dat(d[k]);
    put(~crc[7:0], 1);
    put(~crc[15:8], 1);
    put(`P_FLAG, 0);
    send(3'h2);
    wb(1, `A_CHSEL, 32'h1, q);
    wb(0, `A_STAT, 0, q);
    chk(q[0], 0);
    wb(1, `A_CHSEL, 32'h2, q);
    wb(0, `A_STAT, 0, q);
    chk(q[1:0], 2'b01);
    foreach (d[k])
    begin
      wb(0, `A_RXD, 0, q);
      chk(q[8:0], {1'b1, d[k]});
    end
    wb(0, `A_RXD, 0, q);
    chk(q[8], 0);
  endtask
  task rx_abort;
    wb(1, `A_STAT, 32'h3bf, q);
    open;
    dat(8'h55);
    put(`P_ABORT, 0);
    put(`P_FLAG, 0);
    send(3'h2);
    wb(0, `A_STAT, 0, q);
    chk(q[2:0], 0);
    wb(0, `A_RXD, 0, q);
    chk(q[8], 0);
    open;
    foreach (d[k])
      dat(d[k]);
    dat(8'h00);
    put(`P_ABORT, 0);
    put(`P_FLAG, 0);
    send(3'h2);
    wb(0, `A_STAT, 0, q);
    chk(q[4:2], 3'b001);
    wb(0, `A_RXD, 0, q);
    chk(q[8], 0);
  endtask
  task rx_idle;
    wb(1, `A_CHSEL, 32'h4, q);
    ex = {};
    put(`P_IDLE, 0);
    put(`P_IDLE, 0);
    send(3'h4);
    wb(0, `A_STAT, 0, q);
    chk(q[6:5], 2'b11);
    wb(1, `A_STAT, 32'h20, q);
    ex = {};
    put(`P_FLAG, 0);
    send(3'h4);
    wb(0, `A_STAT, 0, q);
    chk(q[6:5], 2'b01);
  endtask
  task loop_frame;
    logic t;
    wb(1, `A_CHSEL, 32'h6, q);
    wb(1, `A_CFG, 32'h04, q);
    wb(1, `A_TXD, 32'h0a5, q);
    wb(1, `A_TXD, 32'h15a, q);
    repeat (80)
      i_line_partner.slot(1'b0, 1'b1, 3'h6, 1'b1, 3'h6, t);
    wb(0, `A_STAT, 0, q);
    chk(q[1:0], 2'b01);
    wb(0, `A_RXD, 0, q);
    chk(q[8:0], 9'h1a5);
    wb(0, `A_RXD, 0, q);
    chk(q[8:0], 9'h15a);
  endtask
  task tx_halt;
    logic t;
    wb(1, `A_CHSEL, 32'h7, q);
    wb(1, `A_TXD, 32'h011, q);
    repeat (20)
      i_line_partner.slot(1'b0, 1'b0, 3'h0, 1'b1, 3'h7, t);
    wb(1, `A_CFG, 32'h08, q);
    repeat (16)
      i_line_partner.slot(1'b0, 1'b0, 3'h0, 1'b1, 3'h7, t);
    wb(0, `A_STAT, 0, q);
    chk(q[8:7], 2'b10);
  endtask
  task echo_bits;
    logic t, p;
    wb(1, `A_CHSEL, 32'h1, q);
    wb(1, `A_CFG, 32'h02, q);
    p = 1'b1;
    ex = {};
    put(`P_FLAG, 0);
    put(8'h96, 0);
    put(`P_FLAG, 0);
    foreach (ex[k])
    begin
      i_line_partner.slot(ex[k], 1'b1, 3'h1, 1'b1, 3'h1, t);
      chk(t, p);
      p = ex[k];
    end
    wb(0, `A_STAT, 0, q);
    chk(q[0], 0);
  endtask

  ////////////////////////////////////////////////////////////////
  // Main sequence
  initial
  begin
    rst_n    = 1'b0;
    wb_cyc_i = 1'b0;
    wb_stb_i = 1'b0;
    wb_we_i  = 1'b0;
    wb_adr_i = 8'h0;
    wb_sel_i = 4'hf;
    wb_dat_i = 32'h0;
    repeat (16) @(posedge sys_clk);
    rst_n <= 1'b1;
    regs_at_reset;
    tx_frame(3'h3, 0);
    tx_frame(3'h5, 1);
    rx_frame;
    rx_abort;
    rx_idle;
    loop_frame;
    tx_halt;
    echo_bits;
    results;
  end
endmodule
